// ### logic/pcfg_pkg.sv
// Purpose: shared constants and carriers for the static configuration vector
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets are byte addresses
package pcfg_pkg;

  // ==========================================================
  // vector carriers
  typedef struct packed {
    logic [4:0] rsvd_31_27;
    logic rx_reorder;
    logic [9:0] rsvd_25_16;
    logic [3:0] port_type;
    logic rsvd_11;
    logic ref_clk_phy;
    logic [8:0] rsvd_9_1;
    logic compliance;
  } pcfg_gbl_type;

  typedef struct packed {
    logic [2:0] pm_version;
    logic [15:0] subsys_device;
    logic [15:0] subsys_vendor;
    logic [23:0] class_code;
    logic [7:0] revision;
    logic [15:0] device;
    logic [15:0] vendor;
  } pcfg_conf_type;

  localparam int CONF_W = 99;
  localparam int CONF_PAD_W = 128;

  // ==========================================================
  // fixed field values
  localparam logic COMPLIANCE_FIXED = 1'b0;
  localparam logic RX_REORDER_FIXED = 1'b1;
  localparam logic [2:0] PM_VERSION_FIXED = 3'h2;
  localparam logic [3:0] PORT_NATIVE_EP = 4'h0;
  localparam logic [3:0] PORT_LEGACY_EP = 4'h1;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_GBL = 8'h00;
  localparam logic [7:0] OFS_CONF0 = 8'h04;
  localparam logic [7:0] OFS_CONF1 = 8'h08;
  localparam logic [7:0] OFS_CONF2 = 8'h0c;
  localparam logic [7:0] OFS_CONF3 = 8'h10;
  localparam logic [7:0] OFS_SEL = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // ==========================================================
  // field positions and reset values
  localparam int SEL_W = 2;
  localparam int STATUS_ROERR_BIT = 0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic ROERR_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // bus state
  typedef enum logic [0:0] {
    PCFG_IDLE,
    PCFG_ACCESS
  } pcfg_bus_type;

endpackage

// ### logic/pcfg_build.sv
// Purpose: assemble the constant global and configuration words
// Assumes: all inputs are elaboration-time parameters
// Notes: purely combinational, valid from time zero
`timescale 1ns/1ps
module pcfg_build #(
  parameter logic LINK_COMMON_CLK = 1'b0,
  parameter logic [3:0] PORT_TYPE = 4'h0,
  parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5678, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h01, // arbitrary value
  parameter logic [23:0] CLASS_CODE = 24'hff0000,
  parameter logic [15:0] SUBSYS_VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] SUBSYS_DEVICE_ID = 16'h5678 // arbitrary value
) (
  output pcfg_pkg::pcfg_gbl_type gbl_o,
  output pcfg_pkg::pcfg_conf_type conf_o
);
  import pcfg_pkg::*;

  // ==========================================================
  // global control word
  always_comb begin
    gbl_o = '0; // reserved bits stay zero
    gbl_o.compliance = COMPLIANCE_FIXED;
    gbl_o.ref_clk_phy = LINK_COMMON_CLK;
    gbl_o.port_type = PORT_TYPE;
    gbl_o.rx_reorder = RX_REORDER_FIXED;
  end

  // ==========================================================
  // configuration word, identification fields
  always_comb begin
    conf_o.vendor = VENDOR_ID;
    conf_o.device = DEVICE_ID;
    conf_o.revision = REVISION_ID;
    conf_o.class_code = CLASS_CODE;
    conf_o.subsys_vendor = SUBSYS_VENDOR_ID;
    conf_o.subsys_device = SUBSYS_DEVICE_ID;
    conf_o.pm_version = PM_VERSION_FIXED;
  end

endmodule

// ### logic/pcfg_vector.sv
// Purpose: static configuration vector with an apb view for software
// Assumes: apb master per apb4, single clock, synchronous reset
// Notes: vectors are constants; only select and status are writable
//   select picks the configuration slice seen at the data window
//   status bit 0 flags a refused write, write one to clear
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps

// What this block does
// - Global bit 0 picks the compliance level and is held at 0.
// - Global bit 10 tells whether the reference clock drives the phy.
// - Global bits 15:12 carry the port type, 0 native, 1 legacy endpoint.
// - Global bit 26 is held at 1 for receive reordering, other spares zero.
// - The configuration word carries the id fields at their fixed ranges.
// - Configuration bits 98:96 hold the power management version 010.
module pcfg_vector #(
  parameter logic LINK_COMMON_CLK = 1'b0,
  parameter logic [3:0] PORT_TYPE = 4'h0,
  parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5678, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h01, // arbitrary value
  parameter logic [23:0] CLASS_CODE = 24'hff0000,
  parameter logic [15:0] SUBSYS_VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] SUBSYS_DEVICE_ID = 16'h5678 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output pcfg_pkg::pcfg_gbl_type gbl_o,
  output pcfg_pkg::pcfg_conf_type conf_o
);
  import pcfg_pkg::*;

  pcfg_gbl_type gbl_w;
  pcfg_conf_type conf_w;
  logic [CONF_PAD_W-1:0] conf_pad;
  pcfg_bus_type state_ff;
  pcfg_bus_type nxt_state;
  logic [SEL_W-1:0] sel_ff;
  logic [SEL_W-1:0] nxt_sel;
  logic roerr_ff;
  logic nxt_roerr;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic slverr_ff;
  logic nxt_slverr;
  logic setup;
  logic access;
  logic known;
  logic writable;
  logic [31:0] rd_word;
  logic wr_sel;
  logic wr_status;
  logic wr_refused;

  // ==========================================================
  // constant vectors
  pcfg_build #(
    .LINK_COMMON_CLK(LINK_COMMON_CLK),
    .PORT_TYPE(PORT_TYPE),
    .VENDOR_ID(VENDOR_ID),
    .DEVICE_ID(DEVICE_ID),
    .REVISION_ID(REVISION_ID),
    .CLASS_CODE(CLASS_CODE),
    .SUBSYS_VENDOR_ID(SUBSYS_VENDOR_ID),
    .SUBSYS_DEVICE_ID(SUBSYS_DEVICE_ID)
  ) u_build (
    .gbl_o(gbl_w),
    .conf_o(conf_w)
  );

  // outputs not gated by reset, valid from time zero
  assign gbl_o = gbl_w;
  assign conf_o = conf_w;
  assign conf_pad = {{(CONF_PAD_W-CONF_W){1'b0}}, conf_w};

  // ==========================================================
  // helpers
  function automatic logic [31:0] conf_slice(
    input logic [CONF_PAD_W-1:0] vec,
    input logic [SEL_W-1:0] idx
  );
    conf_slice = vec[32*idx +: 32];
  endfunction

  // one lane-0 write of the access phase to a given offset
  function automatic logic wr_hit(
    input logic acc,
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] ofs,
    input logic lane0
  );
    wr_hit = acc & wr & (addr == ofs) & lane0;
  endfunction

  // ==========================================================
  // address decode
  assign setup = psel_i & ~penable_i;
  // access only counts after a setup cycle was seen
  assign access = psel_i & penable_i & (state_ff == PCFG_ACCESS);
  assign wr_sel = wr_hit(access, pwrite_i, paddr_i, OFS_SEL, pstrb_i[0]);
  assign wr_status = wr_hit(access, pwrite_i, paddr_i, OFS_STATUS,
    pstrb_i[0]);
  // refused write to a constant word
  assign wr_refused = access & pwrite_i & known & ~writable;
  assign pready_o = 1'b1; // zero wait state

  always_comb begin
    known = 1'b1;
    writable = 1'b0;
    rd_word = RDATA_RST;
    case (paddr_i)
      OFS_GBL: rd_word = gbl_w;
      OFS_CONF0: rd_word = conf_slice(conf_pad, 2'h0);
      OFS_CONF1: rd_word = conf_slice(conf_pad, 2'h1);
      OFS_CONF2: rd_word = conf_slice(conf_pad, 2'h2);
      OFS_CONF3: rd_word = conf_slice(conf_pad, 2'h3);
      OFS_SEL: begin
        rd_word = {{(32-SEL_W){1'b0}}, sel_ff};
        writable = 1'b1;
      end
      OFS_DATA: rd_word = conf_slice(conf_pad, sel_ff);
      OFS_STATUS: begin
        rd_word = {31'h0, roerr_ff};
        writable = 1'b1;
      end
      default: known = 1'b0;
    endcase
  end

  // ==========================================================
  // bus phase tracking
  always_comb begin
    case (state_ff)
      PCFG_IDLE: begin
        // setup seen, access follows
        nxt_state = setup ? PCFG_ACCESS : PCFG_IDLE;
      end
      PCFG_ACCESS: begin
        // back-to-back setup keeps the phase armed
        nxt_state = setup ? PCFG_ACCESS : PCFG_IDLE;
      end
      default: nxt_state = PCFG_IDLE;
    endcase
  end

  // ==========================================================
  // read data and error, captured in setup phase
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_slverr = slverr_ff;
    if (setup) begin
      nxt_rdata = pwrite_i ? RDATA_RST : rd_word;
      // writes to constant words are refused
      nxt_slverr = ~known | (pwrite_i & ~writable);
    end
  end

  // ==========================================================
  // writable registers
  always_comb begin
    nxt_sel = sel_ff;
    nxt_roerr = roerr_ff;
    if (wr_sel) begin
      nxt_sel = pwdata_i[SEL_W-1:0];
    end
    // write one to clear
    if (wr_status && pwdata_i[STATUS_ROERR_BIT]) begin
      nxt_roerr = 1'b0;
    end
    // a refused write sets the flag; set wins over clear
    if (wr_refused) begin
      nxt_roerr = 1'b1;
    end
  end

  // ==========================================================
  // bus phase register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= PCFG_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // answer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= RDATA_RST;
      slverr_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      slverr_ff <= nxt_slverr;
    end
  end

  // ==========================================================
  // select and sticky status registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_ff <= SEL_RST;
      roerr_ff <= ROERR_RST;
    end else begin
      sel_ff <= nxt_sel;
      roerr_ff <= nxt_roerr;
    end
  end

  // ==========================================================
  // answer outputs, only meaningful in access phase
  assign prdata_o = rdata_ff;
  assign pslverr_o = slverr_ff & access;

endmodule

// ### tb/pcfg_vector_assertions.sv
// Purpose: port-level checks for the static configuration vector
// Assumes: sees only the top ports, single clock domain
// Notes: bound to every pcfg_vector instance at the foot
`timescale 1ns/1ps
module pcfg_chk #(
  parameter logic LINK_COMMON_CLK = 1'b0,
  parameter logic [3:0] PORT_TYPE = 4'h0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire pcfg_pkg::pcfg_gbl_type gbl_o,
  input wire pcfg_pkg::pcfg_conf_type conf_o
);
  import pcfg_pkg::*;
  // ==========================================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // setup cycle then access cycle at one address
  sequence s_acc(logic [7:0] a, logic w);
    psel_i && !penable_i && pwrite_i == w && paddr_i == a
      ##1 psel_i && penable_i;
  endsequence
  property p_compl; gbl_o.compliance == 1'b0; endproperty
  property p_refclk; gbl_o.ref_clk_phy == LINK_COMMON_CLK; endproperty
  property p_port; gbl_o.port_type == PORT_TYPE; endproperty
  property p_reord; (gbl_o & 32'hffff_0bfe) == 32'h0400_0000; endproperty
  property p_rd0;
    s_acc(OFS_CONF0, 1'b0) |-> prdata_o == conf_o[31:0];
  endproperty
  property p_pmver; conf_o.pm_version == 3'h2; endproperty
  property p_const; $stable(gbl_o) && $stable(conf_o); endproperty
  property p_wrgbl; s_acc(OFS_GBL, 1'b1) |-> pslverr_o; endproperty
  a_compl: assert property (p_compl)
    else $error("compliance bit not zero");
  a_refclk: assert property (p_refclk)
    else $error("clock config bit wrong");
  a_port: assert property (p_port)
    else $error("port type field wrong");
  a_reord: assert property (p_reord)
    else $error("reorder or spare bits wrong");
  a_rd0: assert property (p_rd0)
    else $error("first config word read wrong");
  a_pmver: assert property (p_pmver)
    else $error("pm version field wrong");
  a_const: assert property (p_const)
    else $error("vector changed");
  a_wrgbl: assert property (p_wrgbl)
    else $error("write to global word not refused");
endmodule
bind pcfg_vector pcfg_chk #(.LINK_COMMON_CLK(LINK_COMMON_CLK),
  .PORT_TYPE(PORT_TYPE)) pcfg_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .gbl_o(gbl_o), .conf_o(conf_o));

// ### tb/pcfg_far_model.sv
// Purpose: far-side reader of the two constant words
// Assumes: words are plain constants
// Notes: decodes only, never drives the block
`timescale 1ns/1ps
module pcfg_far_model (
  input wire pcfg_pkg::pcfg_gbl_type gbl_i,
  input wire pcfg_pkg::pcfg_conf_type conf_i,
  output logic legacy_o,
  output logic [15:0] vendor_o,
  output logic [2:0] pm_ver_o
);
  import pcfg_pkg::*;
  // ==========================================================
  // decode
  // fields the config space picks up
  assign legacy_o = (gbl_i.port_type == PORT_LEGACY_EP);
  assign vendor_o = conf_i.vendor;
  assign pm_ver_o = conf_i.pm_version;
endmodule

// ### tb/tb_pcie_core_static_config_vector.sv
// Purpose: self-checking bench for pcfg_vector
// Assumes: zero-wait apb slave, synchronous reset
// Notes: non-default parameters so fields are told apart
`timescale 1ns/1ps
module tb_pcie_core_static_config_vector;
  import pcfg_pkg::*;
  // ==========================================================
  // setup
  localparam logic LCC = 1'b1;
  localparam logic [3:0] PT = 4'h1;
  localparam logic [15:0] VID = 16'habcd; // arbitrary value
  localparam logic [15:0] DID = 16'h2468; // arbitrary value
  localparam logic [7:0] RID = 8'h5a; // arbitrary value
  localparam logic [23:0] CLS = 24'h0c0330;
  localparam logic [15:0] SVID = 16'h1357; // arbitrary value
  localparam logic [15:0] SDID = 16'h9bdf; // arbitrary value
  localparam logic [127:0] CX = {29'h0, 3'h2, SDID, SVID, CLS, RID, DID, VID};
  localparam logic [31:0] GX = {5'h0, 1'b1, 10'h0, PT, 1'b0, LCC, 10'h0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [3:0] pst = 4'hf;
  logic [31:0] prd, r;
  logic prdy, perr, e, legacy;
  logic [15:0] vend;
  logic [2:0] pmv;
  pcfg_gbl_type gbl;
  pcfg_conf_type conf;
  int failures = 0;
  int n_checks = 0;
  // free-running clock
  always #20 clk = ~clk;
  pcfg_vector #(.LINK_COMMON_CLK(LCC), .PORT_TYPE(PT), .VENDOR_ID(VID),
    .DEVICE_ID(DID), .REVISION_ID(RID), .CLASS_CODE(CLS),
    .SUBSYS_VENDOR_ID(SVID), .SUBSYS_DEVICE_ID(SDID)) pcfg_vector_i (
    .clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .gbl_o(gbl),
    .conf_o(conf));
  pcfg_far_model pcfg_far_model_i (.gbl_i(gbl), .conf_i(conf),
    .legacy_o(legacy), .vendor_o(vend), .pm_ver_o(pmv));
  // ==========================================================
  // tasks
  task automatic chk(input logic [127:0] g, input logic [127:0] x);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_vec();
    chk(gbl, GX);
    chk(conf, CX[98:0]);
    chk(legacy, 1'b1);
    chk(vend, VID);
    chk(pmv, 3'h2);
    $display("vectors test done");
  endtask
  task automatic t_read();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, OFS_CONF0 + 8'(4 * i), 32'h0);
      chk(r, CX[32 * i +: 32]);
      chk(e, 1'b0);
    end
    apb(1'b0, OFS_GBL, 32'h0);
    chk(r, GX);
    $display("read test done");
  endtask
  task automatic t_ro();
    apb(1'b1, OFS_GBL, 32'hffff_ffff);
    chk(e, 1'b1);
    apb(1'b1, OFS_CONF3, 32'h0);
    chk(e, 1'b1);
    apb(1'b0, OFS_GBL, 32'h0);
    chk(r, GX);
    chk(conf, CX[98:0]);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(r[0], 1'b1);
    apb(1'b1, OFS_STATUS, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(r[0], 1'b0);
    $display("read-only test done");
  endtask
  task automatic t_sel();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_SEL, 32'(i));
      chk(e, 1'b0);
      apb(1'b0, OFS_DATA, 32'h0);
      chk(r, CX[32 * i +: 32]);
    end
    // lane 0 off: select write ignored, no error
    pst <= 4'h0;
    apb(1'b1, OFS_SEL, 32'h0);
    chk(e, 1'b0);
    pst <= 4'hf;
    apb(1'b0, OFS_SEL, 32'h0);
    chk(r, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 1'b1);
    $display("select test done");
  endtask
  // mid-run reset clears select and status, vectors untouched
  task automatic t_rst();
    apb(1'b1, OFS_DATA, 32'h0);
    chk(e, 1'b1);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(gbl, GX);
    chk(conf, CX[98:0]);
    apb(1'b0, OFS_SEL, 32'h0);
    chk(r, 32'(SEL_RST));
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(r, 32'(ROERR_RST));
    $display("reset test done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_vec();
    t_read();
    t_ro();
    t_sel();
    t_rst();
    print_verdict();
  end
  initial begin
    repeat (1000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule
